// ---- rtl/rcps_clk_div.v ----
/*
 * Divided clock enable generator: one-cycle tick every div_sel cycles,
 * plus a level, half duty except at odd div_sel above 1. Assumes div_sel is 1 to 8.
 */
`timescale 1ns/100ps
module rcps_clk_div (
  clk_sys,
  sys_rst,
  div_sel,
  restart,
  tick,
  level
);
  input wire clk_sys;
  input wire sys_rst;
  input wire [3:0] div_sel; // Divide ratio
  input wire restart; // Realign phase on ratio change
  output wire tick; // One pulse per divided period
  output reg level; // Divided clock waveform
  reg [3:0] cnt_reg; // Cycle counter within period
  wire last; // Final cycle of period
  assign last = (cnt_reg >= div_sel - 4'h1);
  assign tick = last;
  // Count cycles and shape the level
  always @(posedge clk_sys) begin
    if (sys_rst || restart) begin
      cnt_reg <= 4'h0;
      level <= 1'b0;
    end else if (last) begin
      cnt_reg <= 4'h0;
      level <= (div_sel == 4'h1) ? ~level : 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
      if (div_sel != 4'h1 && cnt_reg == ((div_sel >> 1) - 4'h1))
        level <= 1'b0;
    end
  end
endmodule // rcps_clk_div

// ---- rtl/rcps_defines.vh ----
/*
 * Constants for the reset and clock phase sequencer.
 * Assumes inclusion by bare name from the sequencer files.
 */
`ifndef RCPS_DEFINES_VH
`define RCPS_DEFINES_VH
`define RCPS_STRETCH_CYCLES 10'h200
`define RCPS_DIV_RESET 4'h8
`define RCPS_DIV_CPU 4'h1
`define RCPS_DIV_HALF 4'h2
`define RCPS_DIV_EIGHTH 4'h8
`define RCPS_PH_ASSERT 2'h0
`define RCPS_PH_STRETCH 2'h1
`define RCPS_PH_RUN 2'h2
`define RCPS_CFG_W 4
`endif

// ---- rtl/rcps_sequencer.v ----
/*
 * Reset sequencer: tracks the external reset pin, stretches the internal
 * reset, selects clock ratios, latches boot straps, gates pin enables.
 * Assumes ref clock is clk_sys; reset pin and host data pins are async.
 */
`timescale 1ns/100ps
`include "rcps_defines.vh"
module rcps_sequencer #(
  parameter STRETCH = `RCPS_STRETCH_CYCLES
) (
  clk_sys,
  sys_rst,
  ext_reset_n,
  clock_mode_sel,
  host_data_pins,
  ext_clock_source_sel,
  internal_reset_n,
  reset_phase,
  cpu_core_tick,
  peripheral_domain_tick,
  ext_memory_domain_tick,
  ext_memory_clock_pin,
  ext_memory_clock_oe,
  aux_clock_output_b,
  aux_clock_output_b_oe,
  aux_clock_output_c,
  boot_config,
  pll_bypass,
  external_memory_port_oe,
  hold_acknowledge_oe,
  bus_request_valid,
  pin_group1_oe,
  pin_group2_oe
);
  input wire clk_sys;
  input wire sys_rst;
  input wire ext_reset_n; // Reset pin, active low
  input wire clock_mode_sel; // High when reference clock is used
  input wire [15:0] host_data_pins; // Strap pins
  input wire ext_clock_source_sel; // Memory clock pin source
  output reg internal_reset_n; // Internal reset, active low
  output reg [1:0] reset_phase; // Current phase
  output wire cpu_core_tick; // Cpu clock enable
  output wire peripheral_domain_tick; // Peripheral clock enable
  output wire ext_memory_domain_tick; // Memory clock enable
  output reg ext_memory_clock_pin; // Memory clock pin value
  output reg ext_memory_clock_oe; // Memory clock pin drive
  output reg aux_clock_output_b; // Aux clock b value
  output reg aux_clock_output_b_oe; // Aux clock b drive
  output reg aux_clock_output_c; // Aux clock c value (always driven)
  output reg [`RCPS_CFG_W-1:0] boot_config; // Latched straps
  output reg pll_bypass; // High while phase-locked loop bypassed
  output reg external_memory_port_oe; // Memory port drive
  output reg hold_acknowledge_oe; // Hold-ack drive
  output reg bus_request_valid; // Bus-request meaningful
  output reg pin_group1_oe; // Group 1 drive
  output reg pin_group2_oe; // Group 2 drive

  reg rst_s1_reg; // Synchroniser first stage
  reg rst_s2_reg; // Synchronised reset pin
  reg [`RCPS_CFG_W-1:0] hd_s1_reg; // Strap synchroniser first stage
  reg [`RCPS_CFG_W-1:0] hd_s2_reg; // Synchronised straps
  reg mode_s1_reg; // Mode select synchroniser first stage
  reg mode_s2_reg; // Synchronised mode select, read by phase logic
  reg [1:0] phase_next; // Next phase
  reg [9:0] str_cnt_reg; // Stretch counter
  reg [3:0] div_cpu; // Ratios for this phase
  reg [3:0] div_half;
  reg [3:0] div_c;
  reg [1:0] phase_prev_reg; // For phase change detection
  wire restart; // Realign dividers
  wire cpu_lvl, per_lvl, mem_lvl, c_lvl; // Divided waveforms
  wire pin_low; // Reset pin asserted
  wire [15:0] div_sel_all; // Ratios: cpu, peripheral, memory, aux c
  wire [3:0] tick_all; // Divider ticks, same order
  wire [3:0] lvl_all; // Divider waveforms, same order

  // Two-flop synchronisers for reset pin and straps
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
      hd_s1_reg <= {`RCPS_CFG_W{1'b0}};
      hd_s2_reg <= {`RCPS_CFG_W{1'b0}};
      mode_s1_reg <= 1'b0;
      mode_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= ext_reset_n;
      rst_s2_reg <= rst_s1_reg;
      // Mode select is a board strap, so it is synchronised as well
      mode_s1_reg <= clock_mode_sel;
      mode_s2_reg <= mode_s1_reg;
      hd_s1_reg <= {host_data_pins[14], host_data_pins[8], host_data_pins[4:3]};
      hd_s2_reg <= hd_s1_reg;
    end
  end
  assign pin_low = ~rst_s2_reg;

  // Phase decision
  always @* begin
    phase_next = reset_phase;
    case (reset_phase)
      `RCPS_PH_ASSERT: begin
        if (!pin_low)
          phase_next = `RCPS_PH_STRETCH;
      end
      `RCPS_PH_STRETCH: begin
        if (pin_low)
          phase_next = `RCPS_PH_ASSERT;
        else if (str_cnt_reg == STRETCH - 10'h1 && mode_s2_reg)
          phase_next = `RCPS_PH_RUN;
      end
      `RCPS_PH_RUN: begin
        if (pin_low)
          phase_next = `RCPS_PH_ASSERT;
      end
      default: phase_next = `RCPS_PH_ASSERT;
    endcase
  end

  // Phase, stretch counter, strap capture, internal reset
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      reset_phase <= `RCPS_PH_ASSERT;
      phase_prev_reg <= `RCPS_PH_ASSERT;
      str_cnt_reg <= 10'h0;
      boot_config <= {`RCPS_CFG_W{1'b0}};
      internal_reset_n <= 1'b0;
      pll_bypass <= 1'b1;
    end else begin
      reset_phase <= phase_next;
      phase_prev_reg <= reset_phase;
      if (reset_phase == `RCPS_PH_STRETCH && phase_next == `RCPS_PH_STRETCH)
        str_cnt_reg <= str_cnt_reg + 10'h1;
      else
        str_cnt_reg <= 10'h0;
      if (reset_phase == `RCPS_PH_ASSERT && !pin_low)
        boot_config <= hd_s2_reg;
      internal_reset_n <= (phase_next == `RCPS_PH_RUN);
      pll_bypass <= 1'b1;
    end
  end

  // Ratio selection per phase
  always @* begin
    if (reset_phase == `RCPS_PH_RUN) begin
      div_cpu = `RCPS_DIV_CPU;
      div_half = `RCPS_DIV_HALF;
      div_c = `RCPS_DIV_EIGHTH;
    end else begin
      div_cpu = `RCPS_DIV_RESET;
      div_half = `RCPS_DIV_RESET;
      div_c = `RCPS_DIV_RESET;
    end
  end
  assign restart = (reset_phase != phase_prev_reg);

  // Ratio per divider, highest slot first
  assign div_sel_all = {div_c, div_half, div_half, div_cpu};

  // One divider per clock domain; all realign together after a phase
  // change so the new ratio starts from a clean period
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_div
      rcps_clk_div u_div (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .div_sel(div_sel_all[4*gi +: 4]),
        .restart(restart),
        .tick(tick_all[gi]),
        .level(lvl_all[gi])
      );
    end
  endgenerate

  // Split the divider outputs back into named clocks
  assign cpu_core_tick = tick_all[0];
  assign peripheral_domain_tick = tick_all[1];
  assign ext_memory_domain_tick = tick_all[2];
  assign cpu_lvl = lvl_all[0];
  assign per_lvl = lvl_all[1];
  assign mem_lvl = lvl_all[2];
  assign c_lvl = lvl_all[3];

  // Pin drive and clock outputs, registered
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      ext_memory_clock_pin <= 1'b0;
      ext_memory_clock_oe <= 1'b0;
      aux_clock_output_b <= 1'b0;
      aux_clock_output_b_oe <= 1'b0;
      aux_clock_output_c <= 1'b0;
      external_memory_port_oe <= 1'b0;
      hold_acknowledge_oe <= 1'b0;
      bus_request_valid <= 1'b0;
      pin_group1_oe <= 1'b0;
      pin_group2_oe <= 1'b0;
    end else if (pin_low) begin
      ext_memory_clock_oe <= 1'b0;
      aux_clock_output_b_oe <= 1'b0;
      aux_clock_output_c <= 1'b0;
      ext_memory_clock_pin <= 1'b0;
      aux_clock_output_b <= 1'b0;
      external_memory_port_oe <= 1'b0;
      hold_acknowledge_oe <= 1'b0;
      bus_request_valid <= 1'b0;
      pin_group1_oe <= 1'b0;
      pin_group2_oe <= 1'b0;
    end else begin
      // Clock pins valid three cycles after the pin rise, inside six periods
      ext_memory_clock_oe <= 1'b1;
      aux_clock_output_b_oe <= 1'b1;
      ext_memory_clock_pin <= ext_clock_source_sel ? cpu_lvl : mem_lvl;
      aux_clock_output_b <= per_lvl;
      aux_clock_output_c <= c_lvl;
      external_memory_port_oe <= internal_reset_n;
      hold_acknowledge_oe <= internal_reset_n;
      bus_request_valid <= internal_reset_n;
      pin_group1_oe <= internal_reset_n;
      pin_group2_oe <= internal_reset_n;
    end
  end
endmodule // rcps_sequencer

// ---- verification/rcps_board.sv ----
/* Board model: reset pin, boot straps and clock mode select.
   Assumes calls from the bench just after a rising clock edge. */
`timescale 1ns/100ps
module rcps_board (
  input wire clk_sys,
  output reg ext_reset_n,
  output reg [15:0] host_data_pins,
  output reg clock_mode_sel
);
  // Power-up: pin low, reference clock selected
  initial begin
    ext_reset_n = 1'b0;
    host_data_pins = 16'h0000;
    clock_mode_sel = 1'b1;
  end
  // Pull the pin low with straps set up long before the rise
  task hold_low(input [15:0] straps);
    begin
      @(posedge clk_sys);
      #1 ext_reset_n = 1'b0;
      host_data_pins = straps;
    end
  endtask
  // Release the pin, hold straps, then let them wander
  task let_go;
    begin
      @(posedge clk_sys);
      #1 ext_reset_n = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1 host_data_pins = ~host_data_pins;
    end
  endtask
endmodule // rcps_board

// ---- verification/rcps_seq_asserts.sv ----
/* Port checker for the reset sequencer.
   Assumes a bind onto rcps_sequencer with the same STRETCH. */
`timescale 1ns/100ps
module rcps_seq_asserts #(parameter STRETCH = 8) (
  input wire clk_sys,
  input wire sys_rst,
  input wire ext_reset_n,
  input wire clock_mode_sel,
  input wire [15:0] host_data_pins,
  input wire ext_clock_source_sel,
  input wire internal_reset_n,
  input wire [1:0] reset_phase,
  input wire cpu_core_tick,
  input wire peripheral_domain_tick,
  input wire ext_memory_domain_tick,
  input wire ext_memory_clock_pin,
  input wire ext_memory_clock_oe,
  input wire aux_clock_output_b_oe,
  input wire aux_clock_output_c,
  input wire [3:0] boot_config,
  input wire external_memory_port_oe,
  input wire hold_acknowledge_oe,
  input wire bus_request_valid,
  input wire pin_group1_oe,
  input wire pin_group2_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire in_str = (reset_phase == 2'h1); // Stretch phase
  wire in_run = (reset_phase == 2'h2); // Run phase
  // Pin low long enough to pass the synchroniser
  sequence s_pin_low; !ext_reset_n [*5]; endsequence
  // Pin rise then five more high cycles
  sequence s_pin_rise; $rose(ext_reset_n) ##1 ext_reset_n [*5]; endsequence
  // Settled in the asserted phase
  sequence s_held; (reset_phase == 2'h0) [*3]; endsequence
  // Settled in the run phase
  sequence s_run; in_run [*4]; endsequence
  a_div8_cpu: assert property (
    s_held ##0 cpu_core_tick |=> (!cpu_core_tick || in_run) [*7]) else $error("cpu tick rate");
  a_run_half: assert property (
    s_run |-> peripheral_domain_tick != $past(peripheral_domain_tick)
      && ext_memory_domain_tick != $past(ext_memory_domain_tick)) else $error("half rate");
  a_mem_follow: assert property (
    s_run ##0 (in_run && !ext_clock_source_sel) [*2]
      |-> ext_memory_clock_pin != $past(ext_memory_clock_pin))
    else $error("memory clock pin");
  a_boot_latch: assert property (
    $rose(in_str) |-> boot_config == {host_data_pins[14], host_data_pins[8], host_data_pins[4:3]})
    else $error("boot straps");
  a_clk_float: assert property (
    s_pin_low |-> !ext_memory_clock_oe && !aux_clock_output_b_oe && !aux_clock_output_c)
    else $error("clock pins in reset");
  a_port_float: assert property (
    s_pin_low |-> !(external_memory_port_oe || hold_acknowledge_oe || bus_request_valid))
    else $error("memory port in reset");
  a_group_float: assert property (
    !internal_reset_n [*2] |-> !(pin_group1_oe || pin_group2_oe)) else $error("pin groups");
  a_clk_valid: assert property (
    s_pin_rise |-> ext_memory_clock_oe && aux_clock_output_b_oe) else $error("clock pins late");
  a_stretch_len: assert property (
    $rose(internal_reset_n) |-> $past(in_str, STRETCH) && !$past(in_str, STRETCH + 1))
    else $error("stretch length");
  a_mode_hold: assert property (
    (in_str && !clock_mode_sel) [*3] |=> !internal_reset_n) else $error("stretch left early");
endmodule // rcps_seq_asserts

// ---- verification/tb.sv ----
/* Self-checking bench for the reset sequencer.
   Assumes rtl/ on the include path; stretch cut to 8 cycles. */
`timescale 1ns/100ps
module tb;
  localparam STRETCH = 8; // Short stretch keeps the run brief
  reg clk_sys = 1'b0; // Reference clock
  reg sys_rst = 1'b1; // Block reset
  reg ext_clock_source_sel = 1'b0; // Memory clock pin source
  wire ext_reset_n, clock_mode_sel, internal_reset_n, cpu_core_tick, peripheral_domain_tick;
  wire ext_memory_domain_tick, ext_memory_clock_pin, ext_memory_clock_oe, aux_clock_output_b;
  wire aux_clock_output_b_oe, aux_clock_output_c, pll_bypass, external_memory_port_oe;
  wire hold_acknowledge_oe, bus_request_valid, pin_group1_oe, pin_group2_oe;
  wire [15:0] host_data_pins;
  wire [1:0] reset_phase;
  wire [3:0] boot_config;
  integer n_mismatch = 0;
  integer n_tests = 0;
  integer i;
  integer n; // Cycles since the pin rose
  reg [15:0] straps; // Straps shown at the rise
  reg [47:0] cnt; // Ticks: cpu, periph, memory; edges: memory pin, aux c rise, aux b
  reg prev_pin;
  reg prev_c;
  reg prev_b;
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  rcps_board u_board (.clk_sys(clk_sys), .ext_reset_n(ext_reset_n),
    .host_data_pins(host_data_pins), .clock_mode_sel(clock_mode_sel));
  rcps_sequencer #(.STRETCH(STRETCH)) u_dut (.*);
  // Expected strap capture
  function [3:0] cfg(input [15:0] h);
    cfg = {h[14], h[8], h[4:3]};
  endfunction
  task check(input [63:0] seen, input [63:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // Bounded wait for the internal reset to lift
  task wait_release;
    begin
      while (internal_reset_n !== 1'b1 && n < 200) begin
        @(posedge clk_sys);
        #1 n = n + 1;
      end
      if (n >= 200) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0t release timeout", $time);
        end_of_test;
      end
    end
  endtask
  // Count ticks and clock-pin edges over 16 cycles
  task measure;
    begin
      cnt = 48'h0;
      repeat (16) begin
        prev_pin = ext_memory_clock_pin;
        prev_c = aux_clock_output_c;
        prev_b = aux_clock_output_b;
        @(posedge clk_sys);
        #1 cnt = cnt + {7'h0, cpu_core_tick, 7'h0, peripheral_domain_tick, 7'h0,
          ext_memory_domain_tick, 7'h0, prev_pin ^ ext_memory_clock_pin, 7'h0,
          !prev_c && aux_clock_output_c, 7'h0, prev_b ^ aux_clock_output_b};
      end
    end
  endtask
  initial begin
    straps = $urandom(32'hA6DD);
    repeat (16) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    for (i = 0; i < 6; i = i + 1) begin
      straps = (i == 0) ? 16'h4118 : (i == 1) ? 16'hBEE7 : $urandom;
      // Pin drops again in mid-stretch on the third pass
      if (i == 2) begin
        u_board.hold_low(straps);
        repeat (6) @(posedge clk_sys);
        u_board.let_go;
      end
      u_board.hold_low(straps);
      repeat (5 + $urandom % 8) @(posedge clk_sys);
      #1 check({ext_memory_clock_oe, aux_clock_output_b_oe, aux_clock_output_c,
        external_memory_port_oe, hold_acknowledge_oe, bus_request_valid, pin_group1_oe,
        pin_group2_oe, internal_reset_n}, 64'h0);
      measure;
      check(cnt, 48'h020202000000);
      u_board.let_go;
      n = 4;
      wait_release;
      check(n, STRETCH + 3);
      check(boot_config, cfg(straps));
      // Let the dividers and clock pins settle on the run ratios first
      repeat (4) @(posedge clk_sys);
      #1 measure;
      check({cnt, pll_bypass, ext_memory_clock_oe, aux_clock_output_b_oe, external_memory_port_oe,
        hold_acknowledge_oe, bus_request_valid, pin_group1_oe, pin_group2_oe, reset_phase},
        {48'h100808100210, 10'h3FE});
    end
    // Clock mode off the reference: stretch must hold
    u_board.hold_low(straps);
    u_board.clock_mode_sel = 1'b0;
    ext_clock_source_sel = 1'b1;
    repeat (6) @(posedge clk_sys);
    u_board.let_go;
    repeat (3 * STRETCH) @(posedge clk_sys);
    #1 check({internal_reset_n, reset_phase}, 64'h1);
    u_board.hold_low(straps);
    u_board.clock_mode_sel = 1'b1;
    repeat (6) @(posedge clk_sys);
    u_board.let_go;
    n = 4;
    wait_release;
    check(n, STRETCH + 3);
    end_of_test;
  end
endmodule // tb
bind rcps_sequencer rcps_seq_asserts #(.STRETCH(STRETCH)) u_chk (.*);
